/* File: ppu_top.sv */
// Functional notes
// R1 - Protected PWM outputs stay safe while any enabled fault source is high.
// R2 - Start: edge policy begins safe; automatic policy follows current fault levels.
// R3 - Status output is 0 in safe state and 1 in normal operation.
// R4 - Unconfigured unit starts normal and never enters safe state; code resets it to safe and returns it to normal on the first clock after reset.
// R5 - Enabled trip input forces safe on any nonzero value; disabled has no effect.
// R6 - Zero to three selectable digital fault inputs monitored; empty selection never trips.
// R7 - Edge policy: after faults clear, stay safe until enable input rises.
// R8 - Automatic policy: resume as soon as all faults are 0, enable ignored.
// R9 - Enable rising edge resumes only if every fault source is 0 then.
// R10 - Safe output level comes from each PWM channel's own setting.
// R11 - Safe setting 0 drives channel low, 1 drives it high, per channel.
// R12 - Four independent protection units, each with its own PWM channels.
// R13 - General output override cannot change channels governed by a protection unit.
// R14 - Faults and enable sampled on system clock; edge compares current and previous.
// R15 - New fault forces safe outputs by the cycle after it is sampled.
`timescale 1ns/1ps
module ppu_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ppu_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ppu_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ppu_pkg::NUM_DIN-1:0] din_pin,
  input wire logic [ppu_pkg::NUM_UNITS-1:0][ppu_pkg::TRIP_W-1:0] trip_val,
  input wire logic [ppu_pkg::NUM_UNITS-1:0] resume_en,
  input wire logic [ppu_pkg::NUM_PWM-1:0] pwm_in,
  output logic [ppu_pkg::NUM_PWM-1:0] pwm_out,
  output logic [ppu_pkg::NUM_UNITS-1:0] unit_ok,
  output logic irq
);

  localparam int NU = ppu_pkg::NUM_UNITS;
  localparam int NP = ppu_pkg::NUM_PWM;
  localparam int ND = ppu_pkg::NUM_DIN;

  logic [31:0] cfg_word_reg [NU];
  logic [NP-1:0] pwm_safe_reg;
  logic [NP-1:0][ppu_pkg::UNIT_IDX_W-1:0] pwm_unit_reg;
  logic [NP-1:0] pwm_prot_reg;
  logic [NP-1:0] ovr_en_reg;
  logic [NP-1:0] ovr_val_reg;
  logic [ppu_pkg::IRQ_W-1:0] irq_status_reg;
  logic [ppu_pkg::IRQ_W-1:0] irq_mask_reg;
  logic restart_reg;
  logic start_pend_reg;
  logic [ND-1:0] din_s1_reg;
  logic [ND-1:0] din_s2_reg;
  logic [ND-1:0] din_s3_reg;
  logic [ND-1:0] din_reg;
  logic [NU-1:0] safe_prev_reg;
  logic [NU-1:0] unit_safe_state;
  logic [NU-1:0] unit_fault;
  logic [NU-1:0] unit_safe_now;
  logic [NU-1:0] unit_cfg_on;
  logic [ppu_pkg::IRQ_W-1:0] irq_event;
  logic [ppu_pkg::IRQ_W-1:0] irq_status_next;
  logic [NP-1:0] pwm_next;

  logic aw_have_reg;
  logic [ppu_pkg::ADDR_W-1:0] aw_addr_reg;
  logic w_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [31:0] wmask;
  logic do_write;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  //////////////////////////////////////////////////////////////////////////////
  // R14 three-stage input sampling, change accepted when stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      din_s1_reg <= '0;
      din_s2_reg <= '0;
      din_s3_reg <= '0;
    end
    else
    begin
      din_s1_reg <= din_pin;
      din_s2_reg <= din_s1_reg;
      din_s3_reg <= din_s2_reg;
    end
  end

  genvar gb;
  generate
    for (gb = 0; gb < ND; gb++)
    begin : g_din
      always_ff @(posedge core_clk)
      begin
        if (!rst_n)
          din_reg[gb] <= 1'b0;
        else if (din_s2_reg[gb] == din_s3_reg[gb])
          din_reg[gb] <= din_s3_reg[gb];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Start strobe: first cycle after reset, or software restart
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      start_pend_reg <= 1'b1;
    else
      start_pend_reg <= 1'b0;
  end

  // R12 four independent units
  genvar gu;
  generate
    for (gu = 0; gu < NU; gu++)
    begin : g_unit
      ppu_pkg::ppu_stat_type stat;
      ppu_pkg::ppu_cfg_type cfg;
      assign cfg = ppu_pkg::ppu_cfg_from_word(cfg_word_reg[gu]);
      assign unit_cfg_on[gu] = cfg.configured;
      assign unit_safe_state[gu] = stat.safe_state;
      assign unit_fault[gu] = stat.fault;
      assign unit_safe_now[gu] = stat.safe_now;
      ppu_unit u_unit (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .init_pulse(start_pend_reg | restart_reg),
        .cfg(cfg),
        .din(din_reg),
        .trip(trip_val[gu]),
        .en(resume_en[gu]),
        .stat(stat)
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // PWM output steering
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_pwm
      logic governed;
      assign governed = pwm_prot_reg[gp] & unit_cfg_on[pwm_unit_reg[gp]];
      always_comb
      begin
        // R10 R11 R15 per-channel safe level
        if (governed && unit_safe_now[pwm_unit_reg[gp]])
          pwm_next[gp] = pwm_safe_reg[gp];
        // R13 override only on ungoverned channels
        else if (!governed && ovr_en_reg[gp])
          pwm_next[gp] = ovr_val_reg[gp];
        else
          pwm_next[gp] = pwm_in[gp];
      end
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      pwm_out <= ppu_pkg::PWM_SAFE_RESET;
    else
      pwm_out <= pwm_next;
  end

  // R3 status output
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      unit_ok <= '0;
    else
      unit_ok <= ~unit_safe_state;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt events: entry into and exit from safe state
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      safe_prev_reg <= '1;
    else
      safe_prev_reg <= unit_safe_state;
  end

  assign irq_event = {safe_prev_reg & ~unit_safe_state, unit_safe_state & ~safe_prev_reg};

  // New events win over a simultaneous write-one-to-clear
  always_comb
  begin
    irq_status_next = irq_status_reg;
    if (do_write && aw_addr_reg == ppu_pkg::ADDR_IRQ_STATUS)
      irq_status_next = irq_status_reg & ~(w_data_reg[ppu_pkg::IRQ_W-1:0]
                                           & wmask[ppu_pkg::IRQ_W-1:0]);
    irq_status_next = irq_status_next | irq_event;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      irq_status_reg <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq_status_reg <= irq_status_next;
      irq <= |(irq_status_next & irq_mask_reg);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel: address and data taken independently
  assign do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  always_comb
  begin
    wr_hit = 1'b0;
    for (int i = 0; i < NU; i++)
      if (aw_addr_reg == ppu_pkg::ADDR_UNIT_CFG0 + 8'(i) * ppu_pkg::ADDR_UNIT_STRIDE)
        wr_hit = 1'b1;
    if (aw_addr_reg == ppu_pkg::ADDR_CTRL || aw_addr_reg == ppu_pkg::ADDR_PWM_SAFE ||
        aw_addr_reg == ppu_pkg::ADDR_PWM_MAP || aw_addr_reg == ppu_pkg::ADDR_OVERRIDE ||
        aw_addr_reg == ppu_pkg::ADDR_STATUS || aw_addr_reg == ppu_pkg::ADDR_IRQ_STATUS ||
        aw_addr_reg == ppu_pkg::ADDR_IRQ_MASK)
      wr_hit = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_have_reg <= 1'b0;
      w_data_reg <= ppu_pkg::WORD_ZERO;
      w_strb_reg <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ppu_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_have_reg & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_have_reg & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? ppu_pkg::RESP_OKAY : ppu_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Register updates under byte enables
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NU; i++)
        cfg_word_reg[i] <= ppu_pkg::CFG_RESET;
      pwm_safe_reg <= ppu_pkg::PWM_SAFE_RESET;
      pwm_unit_reg <= '0;
      pwm_prot_reg <= '0;
      ovr_en_reg <= '0;
      ovr_val_reg <= '0;
      irq_mask_reg <= '0;
      restart_reg <= 1'b0;
    end
    else
    begin
      restart_reg <= 1'b0;
      if (do_write)
      begin
        for (int i = 0; i < NU; i++)
          if (aw_addr_reg == ppu_pkg::ADDR_UNIT_CFG0 + 8'(i) * ppu_pkg::ADDR_UNIT_STRIDE)
            cfg_word_reg[i] <= ((cfg_word_reg[i] & ~wmask) | (w_data_reg & wmask))
                               & ppu_pkg::CFG_WRITE_MASK;
        case (aw_addr_reg)
          ppu_pkg::ADDR_CTRL:
            restart_reg <= w_data_reg[ppu_pkg::CTRL_RESTART_BIT] & wmask[ppu_pkg::CTRL_RESTART_BIT];
          ppu_pkg::ADDR_PWM_SAFE:
            pwm_safe_reg <= (pwm_safe_reg & ~wmask[NP-1:0]) | (w_data_reg[NP-1:0] & wmask[NP-1:0]);
          ppu_pkg::ADDR_PWM_MAP:
          begin
            if (w_strb_reg[0])
              pwm_unit_reg[3:0] <= w_data_reg[7:0];
            if (w_strb_reg[1])
              pwm_unit_reg[7:4] <= w_data_reg[15:8];
            if (w_strb_reg[2])
              pwm_prot_reg <= w_data_reg[ppu_pkg::MAP_PROT_LSB +: NP];
          end
          ppu_pkg::ADDR_OVERRIDE:
          begin
            if (w_strb_reg[0])
              ovr_en_reg <= w_data_reg[NP-1:0];
            if (w_strb_reg[1])
              ovr_val_reg <= w_data_reg[ppu_pkg::OVR_VAL_LSB +: NP];
          end
          ppu_pkg::ADDR_IRQ_MASK:
            irq_mask_reg <= (irq_mask_reg & ~wmask[ppu_pkg::IRQ_W-1:0])
                            | (w_data_reg[ppu_pkg::IRQ_W-1:0] & wmask[ppu_pkg::IRQ_W-1:0]);
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_comb
  begin
    rd_word = ppu_pkg::WORD_ZERO;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ppu_pkg::ADDR_CTRL: rd_word = ppu_pkg::WORD_ZERO;
      ppu_pkg::ADDR_PWM_SAFE: rd_word[NP-1:0] = pwm_safe_reg;
      ppu_pkg::ADDR_PWM_MAP:
      begin
        rd_word[15:0] = pwm_unit_reg;
        rd_word[ppu_pkg::MAP_PROT_LSB +: NP] = pwm_prot_reg;
      end
      ppu_pkg::ADDR_OVERRIDE:
      begin
        rd_word[NP-1:0] = ovr_en_reg;
        rd_word[ppu_pkg::OVR_VAL_LSB +: NP] = ovr_val_reg;
      end
      ppu_pkg::ADDR_STATUS:
      begin
        rd_word[NU-1:0] = ~unit_safe_state;
        rd_word[ppu_pkg::STATUS_FAULT_LSB +: NU] = unit_fault;
      end
      ppu_pkg::ADDR_IRQ_STATUS: rd_word[ppu_pkg::IRQ_W-1:0] = irq_status_reg;
      ppu_pkg::ADDR_IRQ_MASK: rd_word[ppu_pkg::IRQ_W-1:0] = irq_mask_reg;
      default: rd_hit = 1'b0;
    endcase
    for (int i = 0; i < NU; i++)
      if (s_axi_araddr == ppu_pkg::ADDR_UNIT_CFG0 + 8'(i) * ppu_pkg::ADDR_UNIT_STRIDE)
      begin
        rd_word = cfg_word_reg[i];
        rd_hit = 1'b1;
      end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= ppu_pkg::WORD_ZERO;
      s_axi_rresp <= ppu_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? ppu_pkg::RESP_OKAY : ppu_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      else if (!s_axi_rvalid)
        s_axi_arready <= 1'b1;
    end
  end

endmodule

/* File: ppu_core.sv */
`timescale 1ns/1ps
package ppu_pkg;

  localparam int NUM_UNITS = 4;
  localparam int NUM_SLOTS = 3;
  localparam int NUM_DIN = 8;
  localparam int DIN_IDX_W = 3;
  localparam int NUM_PWM = 8;
  localparam int UNIT_IDX_W = 2;
  localparam int TRIP_W = 16;
  localparam int ADDR_W = 8;

  // Byte addresses, one aligned word each
  localparam logic [7:0] ADDR_UNIT_CFG0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_PWM_SAFE = 8'h14;
  localparam logic [7:0] ADDR_PWM_MAP = 8'h18;
  localparam logic [7:0] ADDR_OVERRIDE = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
  localparam logic [7:0] ADDR_UNIT_STRIDE = 8'h04;

  // Unit configuration word layout
  localparam int CFG_CONFIGURED_BIT = 0;
  localparam int CFG_TRIP_EN_BIT = 1;
  localparam int CFG_EDGE_BIT = 2;
  localparam int CFG_SLOT_EN_LSB = 4;
  localparam int CFG_SLOT_IDX_LSB = 8;
  localparam int CFG_SLOT_IDX_STRIDE = 4;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h0007_7777;

  // Other layouts
  localparam int CTRL_RESTART_BIT = 0;
  localparam int MAP_PROT_LSB = 16;
  localparam int OVR_VAL_LSB = 8;
  localparam int STATUS_FAULT_LSB = 4;
  localparam int IRQ_RESUME_LSB = 4;
  localparam int IRQ_W = 2 * NUM_UNITS;

  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [NUM_PWM-1:0] PWM_SAFE_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PPU_NORMAL = 2'b01,
    PPU_SAFE = 2'b10
  } ppu_state_type;

  typedef struct packed {
    logic [NUM_SLOTS-1:0][DIN_IDX_W-1:0] slot_idx;
    logic [NUM_SLOTS-1:0] slot_en;
    logic edge_resume;
    logic trip_en;
    logic configured;
  } ppu_cfg_type;

  typedef struct packed {
    logic safe_state;
    logic fault;
    logic safe_now;
  } ppu_stat_type;

  function automatic ppu_cfg_type ppu_cfg_from_word(input logic [31:0] w);
    ppu_cfg_type c;
    c.configured = w[CFG_CONFIGURED_BIT];
    c.trip_en = w[CFG_TRIP_EN_BIT];
    c.edge_resume = w[CFG_EDGE_BIT];
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      c.slot_en[i] = w[CFG_SLOT_EN_LSB + i];
      c.slot_idx[i] = w[CFG_SLOT_IDX_LSB + i * CFG_SLOT_IDX_STRIDE +: DIN_IDX_W];
    end
    return c;
  endfunction

endpackage

module ppu_unit (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic init_pulse,
  input ppu_pkg::ppu_cfg_type cfg,
  input wire logic [ppu_pkg::NUM_DIN-1:0] din,
  input wire logic [ppu_pkg::TRIP_W-1:0] trip,
  input wire logic en,
  output ppu_pkg::ppu_stat_type stat
);

  logic [ppu_pkg::NUM_SLOTS-1:0] slot_hit;
  logic fault;
  logic en_prev_reg;
  logic en_rise;
  ppu_pkg::ppu_state_type state_reg;
  ppu_pkg::ppu_state_type state_next;

  //////////////////////////////////////////////////////////////////////////////
  // R6 slot monitoring
  genvar gi;
  generate
    for (gi = 0; gi < ppu_pkg::NUM_SLOTS; gi++)
    begin : g_slot
      assign slot_hit[gi] = cfg.slot_en[gi] & din[cfg.slot_idx[gi]];
    end
  endgenerate

  // R5 trip when nonzero
  assign fault = cfg.configured & ((cfg.trip_en & (|trip)) | (|slot_hit));

  // R14 edge detect
  assign en_rise = en & ~en_prev_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      en_prev_reg <= 1'b0;
    else
      en_prev_reg <= en;
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ppu_pkg::PPU_NORMAL:
      begin
        // R1 enter safe on fault
        if (fault)
          state_next = ppu_pkg::PPU_SAFE;
      end
      ppu_pkg::PPU_SAFE:
      begin
        if (fault)
          state_next = ppu_pkg::PPU_SAFE;
        // R7 R9 edge resume
        else if (cfg.edge_resume)
        begin
          if (en_rise)
            state_next = ppu_pkg::PPU_NORMAL;
        end
        // R8 automatic resume
        else
          state_next = ppu_pkg::PPU_NORMAL;
      end
      default: state_next = ppu_pkg::PPU_SAFE;
    endcase
    // R2 start state
    if (init_pulse)
      state_next = (cfg.edge_resume || fault) ? ppu_pkg::PPU_SAFE : ppu_pkg::PPU_NORMAL;
    // R4 unconfigured stays normal
    if (!cfg.configured)
      state_next = ppu_pkg::PPU_NORMAL;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      state_reg <= ppu_pkg::PPU_SAFE;
    else
      state_reg <= state_next;
  end

  // R15 fault bypasses state for outputs
  assign stat = '{safe_state: (state_reg == ppu_pkg::PPU_SAFE), fault: fault,
                  safe_now: (state_reg == ppu_pkg::PPU_SAFE) | fault};

endmodule

/* File: ppu_far_model.sv */
`timescale 1ns/1ps
module ppu_far_model (
  input wire logic core_clk,
  input wire logic [7:0] fault_lvl,
  input wire logic [3:0][15:0] trip_lvl,
  input wire logic [7:0] pwm_lvl,
  output logic [7:0] din_pin,
  output logic [3:0][15:0] trip_val,
  output logic [7:0] pwm_in
);
  initial
  begin
    din_pin = 8'h00;
    trip_val = '0;
    pwm_in = 8'h00;
  end
  // Fault pins are asynchronous, so move them between edges
  always @(negedge core_clk)
    din_pin <= fault_lvl;
  always @(posedge core_clk)
  begin
    trip_val <= trip_lvl;
    pwm_in <= pwm_lvl;
  end
endmodule

/* File: ppu_checker_assertions.sv */
`timescale 1ns/1ps
module ppu_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [ppu_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ppu_pkg::NUM_DIN-1:0] din_pin,
  input wire logic [ppu_pkg::NUM_UNITS-1:0][ppu_pkg::TRIP_W-1:0] trip_val,
  input wire logic [ppu_pkg::NUM_UNITS-1:0] resume_en,
  input wire logic [ppu_pkg::NUM_UNITS-1:0] unit_ok
);
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic aw_got;
  logic w_got;
  logic [3:0][31:0] cfg_q;
  logic [3:0] fault_now;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Config shadow, same edge as the block; full strobes only
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      aw_got <= 1'h0;
      w_got <= 1'h0;
      cfg_q <= '0;
    end
    else if (aw_got && w_got && !s_axi_bvalid)
    begin
      aw_got <= 1'h0;
      w_got <= 1'h0;
      if (aw_q < 8'h10)
        cfg_q[aw_q[3:2]] <= w_q & ppu_pkg::CFG_WRITE_MASK;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_got <= 1'h1;
      if (s_axi_wvalid && s_axi_wready)
        w_got <= 1'h1;
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      aw_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
      w_q <= s_axi_wdata;
  end
  // Raw pin level; the window lengths absorb the input synchroniser
  always_comb
  begin
    for (int u = 0; u < 4; u++)
    begin
      fault_now[u] = cfg_q[u][1] && (|trip_val[u]);
      for (int i = 0; i < 3; i++)
        fault_now[u] = fault_now[u] || (cfg_q[u][4 + i] && din_pin[cfg_q[u][8 + 4 * i +: 3]]);
      fault_now[u] = fault_now[u] && cfg_q[u][0];
    end
  end
  ////////////////////////////////////////
  chk_b_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_b_stands:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_r_stands:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  for (genvar u = 0; u < 4; u++)
  begin : g_unit
    chk_unconf_ok:
      assert property ((!cfg_q[u][0]) [*4] |=> unit_ok[u])
      else $error("unconfigured unit left normal");
    chk_fault_safe:
      assert property (fault_now[u] [*8] |=> !unit_ok[u])
      else $error("unit normal during fault");
    chk_trip_quick:
      assert property (cfg_q[u][0] && cfg_q[u][1] && (|trip_val[u]) |-> ##[1:4] !unit_ok[u])
      else $error("trip not acted on");
    chk_auto_resume:
      assert property ((cfg_q[u][0] && !cfg_q[u][2] && !fault_now[u]) [*8] |=> unit_ok[u])
      else $error("automatic resume missing");
    chk_edge_hold:
      assert property ((cfg_q[u][0] && cfg_q[u][2] && !resume_en[u] && !unit_ok[u]) [*4]
        |=> !unit_ok[u])
      else $error("resume without enable edge");
  end
endmodule
bind ppu_top ppu_checker i_ppu_checker (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .din_pin, .trip_val, .resume_en, .unit_ok);

/* File: ppu_top_test.sv */
`timescale 1ns/1ps
module ppu_top_test;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'h0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_arprot = 3'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'h0;
  logic [7:0] din_pin;
  logic [3:0][15:0] trip_val;
  logic [3:0] resume_en = 4'h0;
  logic [7:0] pwm_in;
  logic [7:0] pwm_out;
  logic [3:0] unit_ok;
  logic irq;
  logic [7:0] fault_lvl = 8'h00;
  logic [3:0][15:0] trip_lvl = '0;
  logic [7:0] pwm_lvl = 8'h01;
  int failures = 0;
  int check_count = 0;

  always #5 core_clk = ~core_clk;

  ppu_top i_ppu_top (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .din_pin,
    .trip_val, .resume_en, .pwm_in, .pwm_out, .unit_ok, .irq);
  ppu_far_model i_ppu_far_model (.core_clk, .fault_lvl, .trip_lvl, .pwm_lvl, .din_pin,
    .trip_val, .pwm_in);
  ////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic await(ref logic flag, input string what);
    int n;
    n = 0;
    @(posedge core_clk);
    while (flag !== 1'h1)
    begin
      n++;
      if (n > 50)
      begin
        failures++;
        $display("[FAIL] %s expected handshake seen timeout", what);
        conclude();
      end
      @(posedge core_clk);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ag;
    logic wg;
    int n;
    ag = 1'h0;
    wg = 1'h0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    // Address and data may be taken on different edges
    while (!(ag && wg) && n < 50)
    begin
      @(posedge core_clk);
      n++;
      if (!ag && s_axi_awready)
      begin
        ag = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!wg && s_axi_wready)
      begin
        wg = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    s_axi_bready <= 1'h1;
    await(s_axi_bvalid, "write response");
    check("bresp", s_axi_bresp, er);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    await(s_axi_arready, "read address");
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    await(s_axi_rvalid, "read data");
    check("rdata", s_axi_rdata, ed);
    check("rresp", s_axi_rresp, er);
    s_axi_rready <= 1'h0;
  endtask
  task automatic wait_unit(input int u, input logic v);
    int n;
    n = 0;
    while (unit_ok[u] !== v && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    check("unit_ok bit", unit_ok[u], v);
  endtask
  task automatic pulse_en(input int u);
    resume_en[u] <= 1'h1;
    @(posedge core_clk);
    resume_en[u] <= 1'h0;
    repeat (10) @(posedge core_clk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge core_clk);
    check("unit_ok", unit_ok, 32'hf);
    rd(ppu_pkg::ADDR_STATUS, 32'h0f, ppu_pkg::RESP_OKAY);
    rd(ppu_pkg::ADDR_IRQ_STATUS, 32'hf0, ppu_pkg::RESP_OKAY);
    wr(ppu_pkg::ADDR_IRQ_STATUS, 32'hff, ppu_pkg::RESP_OKAY);
    rd(ppu_pkg::ADDR_IRQ_STATUS, 32'h0, ppu_pkg::RESP_OKAY);
    rd(ppu_pkg::ADDR_UNIT_CFG0, 32'h0, ppu_pkg::RESP_OKAY);
    wr(8'h2c, 32'h1, ppu_pkg::RESP_SLVERR);
    rd(8'h2c, 32'h0, ppu_pkg::RESP_SLVERR);
    // Unit 0 automatic, watching pin 2; channels 0 and 1 protected
    wr(ppu_pkg::ADDR_IRQ_MASK, 32'h01, ppu_pkg::RESP_OKAY);
    wr(ppu_pkg::ADDR_PWM_SAFE, 32'h02, ppu_pkg::RESP_OKAY);
    wr(ppu_pkg::ADDR_PWM_MAP, 32'h0003_0000, ppu_pkg::RESP_OKAY);
    wr(ppu_pkg::ADDR_OVERRIDE, 32'h0405, ppu_pkg::RESP_OKAY);
    wr(ppu_pkg::ADDR_UNIT_CFG0, 32'h0211, ppu_pkg::RESP_OKAY);
    rd(ppu_pkg::ADDR_UNIT_CFG0, 32'h0211, ppu_pkg::RESP_OKAY);
    check("pwm_out", pwm_out, 32'h05);
    fault_lvl <= 8'h08;
    repeat (12) @(posedge core_clk);
    check("unit_ok", unit_ok, 32'hf);
    fault_lvl <= 8'h04;
    wait_unit(0, 1'h0);
    check("pwm_out", pwm_out, 32'h06);
    check("irq", irq, 32'h1);
    rd(ppu_pkg::ADDR_STATUS, 32'h1e, ppu_pkg::RESP_OKAY);
    wr(ppu_pkg::ADDR_IRQ_STATUS, 32'h01, ppu_pkg::RESP_OKAY);
    check("irq", irq, 32'h0);
    fault_lvl <= 8'h00;
    wait_unit(0, 1'h1);
    check("pwm_out", pwm_out, 32'h05);
    check("irq", irq, 32'h0);
    // Unit 1 waits for an enable edge, trips from the model input
    wr(ppu_pkg::ADDR_UNIT_CFG0 + 8'h04, 32'h7, ppu_pkg::RESP_OKAY);
    wr(ppu_pkg::ADDR_CTRL, 32'h1, ppu_pkg::RESP_OKAY);
    wait_unit(1, 1'h0);
    check("unit_ok", unit_ok, 32'hd);
    // Channel 1 now follows unit 1
    wr(ppu_pkg::ADDR_PWM_MAP, 32'h0003_0004, ppu_pkg::RESP_OKAY);
    @(posedge core_clk);
    check("pwm_out", pwm_out, 32'h07);
    trip_lvl[1] <= 16'h0100;
    repeat (3) @(posedge core_clk);
    pulse_en(1);
    check("unit_ok", unit_ok, 32'hd);
    trip_lvl[1] <= 16'h0000;
    repeat (10) @(posedge core_clk);
    check("unit_ok", unit_ok, 32'hd);
    pulse_en(1);
    wait_unit(1, 1'h1);
    // Unit 2 configured with nothing watched
    wr(ppu_pkg::ADDR_UNIT_CFG0 + 8'h08, 32'h1, ppu_pkg::RESP_OKAY);
    trip_lvl[2] <= 16'hffff;
    repeat (12) @(posedge core_clk);
    check("unit_ok", unit_ok, 32'hf);
    conclude();
  end
endmodule
